// file: sim/test_uart_register_controlled_serial_port.sv
/*
 Self-checking bench for the serial port: register bus tasks, scenarios
 and the closing report. Assumes the peer model and a 100 MHz clock.
*/
`timescale 1ns/1ps
module test_uart_register_controlled_serial_port;
  import usp_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, rxd, txd, ir_tx;
  logic cts, dsr, dcd, rts, dtr, aux_one, aux_two, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic slverr;
  int n_errors = 0;
  int total_checks = 0;
  usp_top dut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RXD(rxd), .TXD(txd), .IR_RX(1'b0), .IR_TX(ir_tx), .CTS(cts), .DSR(dsr), .DCD(dcd),
    .RTS(rts), .DTR(dtr), .AUX_OUT_ONE(aux_one), .AUX_OUT_TWO(aux_two), .IRQ(irq));
  usp_serial_peer peer (.CLK(clk), .TXD(txd), .RXD(rxd));
  ////////////////////////////////////////////////////////////////////////////
  // Clock, 10 ns period
  always #5 clk = ~clk;
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One setup and one access cycle; released after the sampling edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && k < 8) begin
      @(posedge clk);
      k++;
    end
    if (k == 8) begin
      n_errors++;
      report_and_stop();
    end
    rdata = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic w1(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e,
                      input logic [31:0] m = 32'hFFFFFFFF);
    apb(1'b0, a, 32'h0);
    chk(rdata & m, e);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Reset values, masking of writable fields, read-only flags, unmapped place
  task automatic t_regs;
    rchk(OFS_CTL, 32'h300);
    rchk(OFS_LVL, 32'h12);
    rchk(OFS_IEN, 32'h0);
    rchk(OFS_LCR, 32'h0);
    rchk(OFS_FLAG, 32'h90);
    rchk(12'h008, 32'h0);
    chk({31'h0, slverr}, 32'h1);
    w1(OFS_ILP, 32'hFFFFFFFF);
    rchk(OFS_ILP, 32'hFF);
    w1(OFS_IBD, 32'hFFFFFFFF);
    rchk(OFS_IBD, 32'hFFFF);
    w1(OFS_FBD, 32'hFFFFFFFF);
    rchk(OFS_FBD, 32'h3F);
    w1(OFS_IEN, 32'hFFFFFFFF);
    rchk(OFS_IEN, 32'h7FF);
    w1(OFS_LCR, 32'hFE);
    rchk(OFS_LCR, 32'hFE);
    w1(OFS_ERR, 32'hF);
    rchk(OFS_ERR, 32'hF);
    w1(OFS_FLAG, 32'hFFFFFFFF);
    rchk(OFS_FLAG, 32'h90);
  endtask
  // Modem outputs follow control bits; modem inputs show in the flags
  task automatic t_modem;
    w1(OFS_CTL, 32'h3F00);
    @(posedge clk);
    chk({28'h0, aux_two, aux_one, rts, dtr}, 32'hF);
    w1(OFS_CTL, 32'h0500);
    @(posedge clk);
    chk({28'h0, aux_two, aux_one, rts, dtr}, 32'h1);
    cts <= 1'b1;
    dcd <= 1'b1;
    rchk(OFS_FLAG, 32'h5, 32'h7);
    cts <= 1'b0;
    dsr <= 1'b1;
    dcd <= 1'b0;
    rchk(OFS_FLAG, 32'h2, 32'h7);
    dsr <= 1'b0;
  endtask
  // Every character length, busy and empty flags, break output
  task automatic t_tx;
    w1(OFS_IBD, 32'h1);
    w1(OFS_FBD, 32'h0);
    w1(OFS_IEN, 32'h0);
    w1(OFS_ERR, 32'h0);
    w1(OFS_CTL, 32'h319);
    for (int w = 0; w < 4; w++) begin
      w1(OFS_LCR, {25'h0, w[1:0], 5'h00});
      fork
        peer.grab(5 + w, 400);
        w1(OFS_DATA, 32'hA5);
      join
      chk({24'h0, peer.got}, 32'hA5 & ((32'h1 << (5 + w)) - 32'h1));
      chk({31'h0, peer.ok}, 32'h1);
      repeat (32) @(posedge clk);
    end
    fork
      peer.grab(8, 400);
      begin
        w1(OFS_DATA, 32'h3C);
        rchk(OFS_FLAG, 32'h108, 32'h108);
      end
    join
    repeat (32) @(posedge clk);
    rchk(OFS_FLAG, 32'h90, 32'h1B8);
    w1(OFS_LCR, 32'h61);
    repeat (3) @(posedge clk);
    chk({31'h0, txd}, 32'h0);
    w1(OFS_LCR, 32'h60);
    repeat (3) @(posedge clk);
    chk({31'h0, txd}, 32'h1);
    w1(OFS_CTL, 32'h31B);
    w1(OFS_LCR, 32'h61);
    repeat (3) @(posedge clk);
    chk({30'h0, txd, ir_tx}, 32'h3);
    w1(OFS_LCR, 32'h60);
    w1(OFS_CTL, 32'h319);
  endtask
  // Parity good and bad, break, error status, interrupt mask and clear
  task automatic t_rx;
    w1(OFS_LCR, 32'h66);
    w1(OFS_IEN, 32'h100);
    peer.send({1'b1, 1'b1, 8'h01, 1'b0}, 11);
    rchk(OFS_DATA, 32'h001, 32'hFFF);
    peer.send({1'b1, 1'b0, 8'h01, 1'b0}, 11);
    rchk(OFS_DATA, 32'h201, 32'hFFF);
    rchk(OFS_ERR, 32'h2, 32'h2);
    chk({31'h0, irq}, 32'h1);
    rchk(OFS_MSK, 32'h100, 32'h100);
    w1(OFS_CLR, 32'h100);
    rchk(OFS_RAW, 32'h0, 32'h100);
    chk({31'h0, irq}, 32'h0);
    peer.send(12'h000, 11);
    repeat (16) @(posedge clk);
    peer.send({1'b1, 1'b1, 8'h01, 1'b0}, 11);
    repeat (32) @(posedge clk);
    rchk(OFS_DATA, 32'h400, 32'h4FF);
    rchk(OFS_ERR, 32'hC, 32'hC);
  endtask
  // Loopback, then flow control holding a full send queue
  task automatic t_loop_flow;
    w1(OFS_LCR, 32'h60);
    w1(OFS_CTL, 32'h399);
    w1(OFS_DATA, 32'h5A);
    repeat (200) @(posedge clk);
    rchk(OFS_DATA, 32'h85A, 32'hFFF);
    w1(OFS_CTL, 32'h8319);
    w1(OFS_LCR, 32'h70);
    for (int i = 0; i < 33; i++) begin
      w1(OFS_DATA, 32'(i));
    end
    rchk(OFS_FLAG, 32'h20, 32'hA0);
    chk({31'h0, txd}, 32'h1);
    cts <= 1'b1;
    peer.grab(8, 400);
    chk({24'h0, peer.got}, 32'h0);
    chk({31'h0, peer.ok}, 32'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    cts = 1'b0;
    dsr = 1'b0;
    dcd = 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_modem();
    t_tx();
    t_rx();
    t_loop_flow();
    report_and_stop();
  end
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end
endmodule

// file: sim/usp_serial_peer.sv
/*
 Far serial device: sends raw line bits on RXD and captures frames
 from TXD. Assumes one bit lasts BIT cycles of CLK (divisor 1, no fraction).
*/
`timescale 1ns/1ps
module usp_serial_peer #(
  parameter int BIT = 16
) (
  input wire logic CLK,
  input wire logic TXD,
  output logic RXD
);
  logic [7:0] got;
  logic ok;
  // Idle line is high
  initial begin
    RXD = 1'b1;
    got = 8'h00;
    ok = 1'b0;
  end
  // Shifts n line bits, LSB first; start, parity and stop come from the caller
  task automatic send(input logic [11:0] seq, input int n);
    for (int i = 0; i < n; i++) begin
      RXD <= seq[i];
      repeat (BIT) @(posedge CLK);
    end
    RXD <= 1'b1;
  endtask
  // Waits a bounded time for a start bit, samples n data bits mid-bit
  task automatic grab(input int n, input int lim);
    int k;
    k = 0;
    ok = 1'b0;
    got = 8'h00;
    while (TXD !== 1'b0 && k < lim) begin
      @(posedge CLK);
      k++;
    end
    if (k < lim) begin
      repeat (BIT / 2) @(posedge CLK);
      ok = (TXD === 1'b0);
      for (int i = 0; i < n; i++) begin
        repeat (BIT) @(posedge CLK);
        got[i] = TXD;
      end
      repeat (BIT) @(posedge CLK);
      ok = ok && (TXD === 1'b1);
    end
  endtask
endmodule

// file: verilog/usp_pkg.sv
/*
 Constants for the register-controlled serial port: offsets, field
 positions, reset values and counts. Assumes a single 100 MHz clock.
*/
// Summary of operation
// - Data port write queues a byte for sending; read pops oldest received byte.
// - Each popped character carries overrun, break, parity, framing flags in 11:8.
// - Error status holds sticky overrun, break, parity, framing in bits 3:0.
// - Flags show transmitter active in bit 8, port busy in bit 3.
// - Flags show send queue empty in bit 7, full in bit 5.
// - Flags show receive queue full in bit 6, empty in bit 4.
// - Flags mirror carrier detect, set ready, clear to send in bits 2:0.
// - Eight-bit infrared pulse divisor, reset zero, times low-power pulses.
// - Sixteen-bit integer and six-bit fractional baud divisors, both reset zero.
// - Character length field 6:5 selects five to eight data bits.
// - Parity enable bit 1, even select bit 2, stick select bit 7.
// - Line control bit 3 selects two stop bits instead of one.
// - Line control bit 4 enables both queues; resets to zero.
// - Line control bit 0 holds the serial output in break.
// - Control bits 15 and 14 enable clear-to-send and request-to-send flow.
// - Control bits 13:10 drive aux two, aux one, request to send, terminal ready.
// - Receive and transmit enables reset to one; port enable resets zero.
// - Control bit 7 loops transmitted data into the receiver.
// - Clock choice field 6:4: code zero stops the clock, any other code runs it at one rate; bit 3 gates it.
// - Control bit 1 enables the infrared codec, bit 2 its low-power pulses.
// - Receive and transmit queue thresholds at 5:3 and 2:0, reset two.
// - Eleven interrupt enables, all reset zero, overflow down to send complete.
// - Masked status equals raw status gated by the matching enable.
// - Writing one to the clear register clears that raw status bit.
// - Serial clock over sixteen times baud equals integer plus fraction divisor.
// - Send queue 32 by 8, receive queue 32 by 12 with error flags.
package usp_pkg;
  localparam logic [11:0] OFS_DATA = 12'h000;
  localparam logic [11:0] OFS_ERR = 12'h004;
  localparam logic [11:0] OFS_FLAG = 12'h018;
  localparam logic [11:0] OFS_ILP = 12'h020;
  localparam logic [11:0] OFS_IBD = 12'h024;
  localparam logic [11:0] OFS_FBD = 12'h028;
  localparam logic [11:0] OFS_LCR = 12'h02C;
  localparam logic [11:0] OFS_CTL = 12'h030;
  localparam logic [11:0] OFS_LVL = 12'h034;
  localparam logic [11:0] OFS_IEN = 12'h038;
  localparam logic [11:0] OFS_RAW = 12'h03C;
  localparam logic [11:0] OFS_MSK = 12'h040;
  localparam logic [11:0] OFS_CLR = 12'h044;
  // Line control fields
  localparam int L_BREAK = 0;
  localparam int L_PAR_ON = 1;
  localparam int L_EVEN = 2;
  localparam int L_STOP2 = 3;
  localparam int L_QUEUE = 4;
  localparam int L_WLO = 5;
  localparam int L_STICK = 7;
  // Control fields
  localparam int C_EN = 0;
  localparam int C_IR = 1;
  localparam int C_IRLP = 2;
  localparam int C_CKG = 3;
  localparam int C_CKS = 4;
  localparam int C_LOOP = 7;
  localparam int C_TX_ON = 8;
  localparam int C_RX_ON = 9;
  localparam int C_MDM = 10;
  localparam int C_RTSF = 14;
  localparam int C_CTSF = 15;
  localparam logic [15:0] CTL_RST = 16'h0300;
  localparam logic [5:0] LVL_RST = 6'h12;
  localparam logic [2:0] CLOCK_OFF_CODE = 3'h0;
  // Raw status bit positions
  localparam int I_OE = 10;
  localparam int I_BE = 9;
  localparam int I_PE = 8;
  localparam int I_FE = 7;
  localparam int I_RT = 6;
  localparam int I_TX = 5;
  localparam int I_RX = 4;
  localparam int I_DSR = 3;
  localparam int I_DCD = 2;
  localparam int I_CTS = 1;
  localparam int I_TXC = 0;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] IR_NARROW = 4'h3;
  localparam logic [8:0] RT_LAST = 9'h1FF;
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP} usp_bit_e;
endpackage

// file: verilog/usp_top.sv
/*
 Register-controlled asynchronous serial port with APB-style slave,
 32-entry send and receive queues, fractional baud generator, modem
 lines and an infrared pulse path. Assumes inputs synchronous to CLK.
*/
`timescale 1ns/1ps
module usp_top #(
  parameter int DEPTH = 32
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic RXD,
  output logic TXD,
  input wire logic IR_RX,
  output logic IR_TX,
  input wire logic CTS,
  input wire logic DSR,
  input wire logic DCD,
  output logic RTS,
  output logic DTR,
  output logic AUX_OUT_ONE,
  output logic AUX_OUT_TWO,
  output logic IRQ
);
  import usp_pkg::*;
  localparam int AW = $clog2(DEPTH);
  // Elaboration check: queue pointers wrap only at a power of two
  if (DEPTH < 8 || DEPTH != (1 << AW)) begin : g_depth_check
    $error("DEPTH must be a power of two of at least eight");
  end

  logic [3:0] err_sts;
  logic [7:0] ilp_div;
  logic [15:0] baud_int;
  logic [5:0] baud_frac;
  logic [7:0] lcr;
  logic [15:0] ctl;
  logic [5:0] lvl;
  logic [10:0] ien;
  logic [10:0] raw;
  logic [7:0] tx_mem [DEPTH];
  logic [11:0] rx_mem [DEPTH];
  logic [AW-1:0] tx_wp, tx_rp, rx_wp, rx_rp;
  logic [AW:0] tx_cnt, rx_cnt, cap;
  logic tx_full, tx_empty, rx_full, rx_empty;
  logic bus_wr, bus_rd, mapped;
  logic tx_push, tx_pop, rx_push, rx_pop, rx_done, oe_pend;
  logic [11:0] rx_word;
  logic [10:0] ev;
  usp_bit_e tx_st;
  logic busy;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode: one wait-free access, unmapped offsets answer an error
  assign bus_wr = PSEL && PENABLE && PWRITE;
  assign bus_rd = PSEL && PENABLE && !PWRITE;
  always_comb begin
    case (PADDR)
      OFS_DATA, OFS_ERR, OFS_FLAG, OFS_ILP, OFS_IBD, OFS_FBD, OFS_LCR,
      OFS_CTL, OFS_LVL, OFS_IEN, OFS_RAW, OFS_MSK, OFS_CLR: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;

  // Read data latched in the setup phase, valid through the access phase
  always_ff @(posedge CLK) begin
    if (RST) begin
      PRDATA <= 32'h0;
    end else if (PSEL && !PENABLE) begin
      case (PADDR)
        OFS_DATA: PRDATA <= {20'h0, rx_mem[rx_rp]};
        OFS_ERR: PRDATA <= {28'h0, err_sts};
        OFS_FLAG: PRDATA <= {23'h0, tx_st != ST_IDLE, tx_empty, rx_full, tx_full, rx_empty,
          busy, DCD, DSR, CTS};
        OFS_ILP: PRDATA <= {24'h0, ilp_div};
        OFS_IBD: PRDATA <= {16'h0, baud_int};
        OFS_FBD: PRDATA <= {26'h0, baud_frac};
        OFS_LCR: PRDATA <= {24'h0, lcr};
        OFS_CTL: PRDATA <= {16'h0, ctl};
        OFS_LVL: PRDATA <= {26'h0, lvl};
        OFS_IEN: PRDATA <= {21'h0, ien};
        OFS_RAW: PRDATA <= {21'h0, raw};
        OFS_MSK: PRDATA <= {21'h0, raw & ien};
        default: PRDATA <= 32'h0;
      endcase
    end
  end

  // Software configuration registers
  always_ff @(posedge CLK) begin
    if (RST) begin
      ilp_div <= 8'h0;
      baud_int <= 16'h0;
      baud_frac <= 6'h0;
      lcr <= 8'h0;
      ctl <= CTL_RST;
      lvl <= LVL_RST;
      ien <= 11'h0;
    end else if (bus_wr) begin
      case (PADDR)
        OFS_ILP: ilp_div <= PWDATA[7:0];
        OFS_IBD: baud_int <= PWDATA[15:0];
        OFS_FBD: baud_frac <= PWDATA[5:0];
        OFS_LCR: lcr <= PWDATA[7:0];
        OFS_CTL: ctl <= PWDATA[15:0];
        OFS_LVL: lvl <= PWDATA[5:0];
        OFS_IEN: ien <= PWDATA[10:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Queues: depth one while queues are disabled
  assign cap = lcr[L_QUEUE] ? (AW+1)'(DEPTH) : (AW+1)'(1);
  assign tx_full = tx_cnt >= cap;
  assign tx_empty = tx_cnt == '0;
  assign rx_full = rx_cnt >= cap;
  assign rx_empty = rx_cnt == '0;
  assign tx_push = bus_wr && PADDR == OFS_DATA && !tx_full;
  assign rx_pop = bus_rd && PADDR == OFS_DATA && !rx_empty;
  assign rx_push = rx_done && !rx_full;

  always_ff @(posedge CLK) begin
    if (tx_push) tx_mem[tx_wp] <= PWDATA[7:0];
    if (rx_push) rx_mem[rx_wp] <= rx_word;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      tx_wp <= '0;
      tx_rp <= '0;
      tx_cnt <= '0;
      rx_wp <= '0;
      rx_rp <= '0;
      rx_cnt <= '0;
    end else begin
      tx_wp <= tx_wp + AW'(tx_push);
      tx_rp <= tx_rp + AW'(tx_pop);
      tx_cnt <= tx_cnt + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
      rx_wp <= rx_wp + AW'(rx_push);
      rx_rp <= rx_rp + AW'(rx_pop);
      rx_cnt <= rx_cnt + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Baud generator: 16x tick every (int + frac/64) cycles
  logic [15:0] bcnt;
  logic [5:0] facc;
  logic extra, tick, baud_run;
  logic [6:0] next_facc;
  assign baud_run = ctl[C_EN] && ctl[C_CKG] && ctl[C_CKS +: 3] != CLOCK_OFF_CODE
    && baud_int != 16'h0;
  assign next_facc = {1'b0, facc} + {1'b0, baud_frac};
  always_ff @(posedge CLK) begin
    if (RST || !baud_run) begin
      bcnt <= 16'h0;
      facc <= 6'h0;
      extra <= 1'b0;
      tick <= 1'b0;
    end else if (bcnt >= baud_int - 16'h1 + 16'(extra)) begin
      bcnt <= 16'h0;
      facc <= next_facc[5:0];
      extra <= next_facc[6];
      tick <= 1'b1;
    end else begin
      bcnt <= bcnt + 16'h1;
      tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmitter
  logic [3:0] tsub;
  logic [2:0] tbit;
  logic [7:0] tsh;
  logic tpar, tx_bit, tstop2, tx_line, tx_go;
  logic [7:0] lp_cnt;
  logic [7:0] wmask;
  assign wmask = 8'hFF >> (3'h3 - {1'b0, lcr[L_WLO +: 2]});
  assign tx_go = ctl[C_EN] && ctl[C_TX_ON] && !tx_empty && (!ctl[C_CTSF] || CTS);
  assign tx_pop = tx_st == ST_IDLE && tick && tx_go;
  assign busy = tx_st != ST_IDLE || !tx_empty;

  always_ff @(posedge CLK) begin
    if (RST) begin
      tx_st <= ST_IDLE;
      tsub <= 4'h0;
      tbit <= 3'h0;
      tsh <= 8'h0;
      tpar <= 1'b0;
      tx_bit <= 1'b1;
      tstop2 <= 1'b0;
    end else if (tick) begin
      tsub <= tsub + 4'h1;
      case (tx_st)
        ST_IDLE: begin
          tsub <= 4'h0;
          tx_bit <= 1'b1;
          if (tx_go) begin
            tsh <= tx_mem[tx_rp] & wmask;
            tpar <= lcr[L_STICK] ? !lcr[L_EVEN]
              : (^(tx_mem[tx_rp] & wmask)) ^ !lcr[L_EVEN];
            tx_bit <= 1'b0;
            tbit <= 3'h0;
            tx_st <= ST_START;
          end
        end
        ST_START, ST_DATA: begin
          if (tsub == OVS_LAST) begin
            if (tx_st == ST_DATA && tbit == {1'b1, lcr[L_WLO +: 2]}) begin
              tx_st <= lcr[L_PAR_ON] ? ST_PAR : ST_STOP;
              tx_bit <= lcr[L_PAR_ON] ? tpar : 1'b1;
              tstop2 <= lcr[L_STOP2];
            end else begin
              tbit <= tbit + 3'(tx_st == ST_DATA);
              tx_bit <= tsh[0];
              tsh <= tsh >> 1;
              tx_st <= ST_DATA;
            end
          end
        end
        ST_PAR: begin
          if (tsub == OVS_LAST) begin
            tx_bit <= 1'b1;
            tstop2 <= lcr[L_STOP2];
            tx_st <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (tsub == OVS_LAST) begin
            tstop2 <= 1'b0;
            if (!tstop2) tx_st <= ST_IDLE;
          end
        end
        default: tx_st <= ST_IDLE;
      endcase
    end
  end

  // Pin drive, break override and infrared pulse shaping
  assign tx_line = tx_bit && !lcr[L_BREAK];
  always_ff @(posedge CLK) begin
    if (RST) begin
      lp_cnt <= 8'h0;
    end else if (tick && tsub == 4'h0) begin
      lp_cnt <= ilp_div;
    end else if (lp_cnt != 8'h0) begin
      lp_cnt <= lp_cnt - 8'h1;
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      TXD <= 1'b1;
      IR_TX <= 1'b0;
      RTS <= 1'b0;
      DTR <= 1'b0;
      AUX_OUT_ONE <= 1'b0;
      AUX_OUT_TWO <= 1'b0;
    end else begin
      TXD <= ctl[C_IR] ? 1'b1 : tx_line;
      IR_TX <= ctl[C_IR] && !tx_line && (ctl[C_IRLP] ? lp_cnt != 8'h0
        : tsub < IR_NARROW);
      RTS <= ctl[C_RTSF] ? !rx_full : ctl[C_MDM+1];
      DTR <= ctl[C_MDM];
      AUX_OUT_ONE <= ctl[C_MDM+2];
      AUX_OUT_TWO <= ctl[C_MDM+3];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receiver, sampled mid-bit at 16x
  usp_bit_e rx_st;
  logic [3:0] rsub;
  logic [2:0] rbit;
  logic [7:0] rsh;
  logic rline, rpe, rzero;
  always_ff @(posedge CLK) begin
    if (RST) rline <= 1'b1;
    else rline <= ctl[C_LOOP] ? tx_line : (ctl[C_IR] ? !IR_RX : RXD);
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      rx_st <= ST_IDLE;
      rsub <= 4'h0;
      rbit <= 3'h0;
      rsh <= 8'h0;
      rpe <= 1'b0;
      rzero <= 1'b1;
      rx_done <= 1'b0;
      rx_word <= 12'h0;
    end else begin
      rx_done <= 1'b0;
      if (tick && ctl[C_EN] && ctl[C_RX_ON]) begin
        rsub <= rsub + 4'h1;
        case (rx_st)
          ST_IDLE: begin
            rsub <= 4'h0;
            rzero <= 1'b1;
            rbit <= 3'h0;
            rsh <= 8'h0;
            if (!rline) rx_st <= ST_START;
          end
          ST_START: begin
            if (rsub == OVS_MID) begin
              rsub <= 4'h0;
              rx_st <= rline ? ST_IDLE : ST_DATA;
            end
          end
          ST_DATA: begin
            if (rsub == OVS_LAST) begin
              rsh[rbit] <= rline;
              rzero <= rzero && !rline;
              rbit <= rbit + 3'h1;
              if (rbit == {1'b1, lcr[L_WLO +: 2]}) rx_st <= lcr[L_PAR_ON] ? ST_PAR : ST_STOP;
            end
          end
          ST_PAR: begin
            if (rsub == OVS_LAST) begin
              rzero <= rzero && !rline;
              rpe <= rline != (lcr[L_STICK] ? !lcr[L_EVEN]
                : (^rsh) ^ !lcr[L_EVEN]);
              rx_st <= ST_STOP;
            end
          end
          ST_STOP: begin
            if (rsub == OVS_LAST) begin
              rx_done <= 1'b1;
              rx_word <= {oe_pend, rzero && !rline, rpe && lcr[L_PAR_ON] && !rzero,
                !rline && !rzero, rsh};
              rpe <= 1'b0;
              rx_st <= ST_IDLE;
            end
          end
          default: rx_st <= ST_IDLE;
        endcase
      end
    end
  end

  // Overrun: the lost character marks the next stored one
  always_ff @(posedge CLK) begin
    if (RST) oe_pend <= 1'b0;
    else if (rx_done && rx_full) oe_pend <= 1'b1;
    else if (rx_push) oe_pend <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky error status and raw interrupt status; set wins over clear
  logic [2:0] mdm_q;
  logic [8:0] rt_cnt;
  logic [AW:0] rx_thr, tx_thr;
  function automatic logic [AW:0] lvl_cnt(input logic [2:0] s);
    case (s)
      3'h0: lvl_cnt = (AW+1)'(DEPTH / 8);
      3'h1: lvl_cnt = (AW+1)'(DEPTH / 4);
      3'h2: lvl_cnt = (AW+1)'(DEPTH / 2);
      3'h3: lvl_cnt = (AW+1)'(DEPTH * 3 / 4);
      default: lvl_cnt = (AW+1)'(DEPTH * 7 / 8);
    endcase
  endfunction
  assign rx_thr = lvl_cnt(lvl[5:3]);
  assign tx_thr = lvl_cnt(lvl[2:0]);
  assign ev = {rx_done && rx_full, rx_push && rx_word[10], rx_push && rx_word[9],
    rx_push && rx_word[8], rt_cnt == RT_LAST, tx_cnt <= tx_thr && tx_cnt != '0,
    rx_cnt >= rx_thr, mdm_q[2] != DSR, mdm_q[1] != DCD, mdm_q[0] != CTS,
    tick && tx_st == ST_STOP && tsub == OVS_LAST && !tstop2 && tx_empty};

  always_ff @(posedge CLK) begin
    if (RST) begin
      err_sts <= 4'h0;
      raw <= 11'h0;
      mdm_q <= 3'h0;
      rt_cnt <= 9'h0;
    end else begin
      mdm_q <= {DSR, DCD, CTS};
      rt_cnt <= (rx_empty || rx_push || rx_pop || rx_st != ST_IDLE) ? 9'h0
        : rt_cnt + 9'(tick && rt_cnt != RT_LAST);
      err_sts <= ((bus_wr && PADDR == OFS_ERR) ? PWDATA[3:0] : err_sts)
        | ev[I_OE:I_FE];
      raw <= (raw & ~((bus_wr && PADDR == OFS_CLR) ? PWDATA[10:0] : 11'h0)) | ev;
    end
  end
  assign IRQ = |(raw & ien);

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_break_line: assert property (@(posedge CLK) disable iff (RST)
    $past(lcr[L_BREAK] && !ctl[C_IR]) |-> !TXD) else $error("break not driven");
  a_push_count: assert property (@(posedge CLK) disable iff (RST)
    tx_push && !tx_pop |=> tx_cnt == $past(tx_cnt) + 1'b1) else $error("push lost");
  a_ctl_reset: assert property (@(posedge CLK)
    $fell(RST) |-> ctl[C_RX_ON] && ctl[C_TX_ON] && !ctl[C_EN] && lvl == LVL_RST)
    else $error("control reset value wrong");
  a_clear_raw: assert property (@(posedge CLK) disable iff (RST)
    bus_wr && PADDR == OFS_CLR && PWDATA[I_TXC] && !ev[I_TXC] |=> !raw[I_TXC])
    else $error("raw bit not cleared");
  a_rts_flow: assert property (@(posedge CLK) disable iff (RST)
    $past(ctl[C_RTSF]) |-> RTS == !$past(rx_full)) else $error("flow output wrong");
  a_loop_path: assert property (@(posedge CLK) disable iff (RST)
    $past(ctl[C_LOOP]) |-> rline == $past(tx_line)) else $error("loopback broken");
  a_overrun_sticky: assert property (@(posedge CLK) disable iff (RST)
    rx_done && rx_full |=> err_sts[3] && raw[I_OE] ##1 oe_pend || rx_cnt != $past(rx_cnt))
    else $error("overrun not recorded");
  a_mask_irq: assert property (@(posedge CLK) disable iff (RST)
    raw[I_PE] && ien[I_PE] |-> IRQ) else $error("masked status not raised");
endmodule
